// file: common/fst_pkg.sv
// Constants shared by the frame start trigger control block.
package fst_pkg;
  // ****************************************************************
  // Clock and register map
  // ****************************************************************
  localparam int unsigned CLK_HZ           = 50000000;
  localparam logic [7:0]  CTRL_OFS         = 8'h00;
  localparam logic [7:0]  CMD_OFS          = 8'h04;
  localparam logic [7:0]  RATE_PERIOD_OFS  = 8'h08;
  localparam logic [7:0]  MIN_PERIOD_OFS   = 8'h0c;
  localparam logic [7:0]  EXPOSURE_OFS     = 8'h10;
  localparam logic [7:0]  FRAMES_OFS       = 8'h14;
  localparam logic [7:0]  READOUT_OFS      = 8'h18;
  localparam logic [7:0]  STATUS_OFS       = 8'h1c;
  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int unsigned CTRL_STD_MODE    = 0;
  localparam int unsigned CTRL_FRAME_TRIG  = 1;
  localparam int unsigned CTRL_FRAME_SRC   = 2;
  localparam int unsigned CTRL_EDGE_POL    = 3;
  localparam int unsigned CTRL_ACQ_MODE    = 4;
  localparam int unsigned CTRL_RATE_LIMIT  = 5;
  localparam int unsigned CTRL_ACQ_TRIG    = 6;
  localparam int unsigned CTRL_ACQ_SRC     = 7;
  localparam int unsigned CTRL_TRIG_KIND   = 8;
  localparam int unsigned CTRL_EXP_WIDTH   = 9;
  localparam int unsigned CTRL_BITS        = 10;
  localparam logic [9:0]  CTRL_RESET       = 10'h000;
  // ****************************************************************
  // Command register fields, status fields and reset values
  // ****************************************************************
  localparam int unsigned CMD_BEGIN        = 0;
  localparam int unsigned CMD_END          = 1;
  localparam int unsigned CMD_SW_TRIG      = 2;
  localparam int unsigned STAT_WAIT_FRAME  = 0;
  localparam int unsigned STAT_WAIT_ACQ    = 1;
  localparam int unsigned STAT_EXPOSING    = 2;
  localparam int unsigned STAT_READOUT     = 3;
  localparam int unsigned STAT_COUNT_LSB   = 16;
  localparam logic [31:0] RATE_PERIOD_RESET = 32'h000f_4240;
  localparam logic [31:0] MIN_PERIOD_RESET  = 32'h0000_1000;
  localparam logic [31:0] EXPOSURE_RESET    = 32'h0000_0800;
  localparam logic [31:0] FRAMES_RESET      = 32'h0000_0001;
  localparam logic [31:0] READOUT_RESET     = 32'h0000_0400;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_WAIT_ACQ   = 3'b001,
    ST_WAIT_FRAME = 3'b010,
    ST_EXPOSE     = 3'b011,
    ST_READOUT    = 3'b100
  } acq_state_t;
endpackage : fst_pkg

// file: common/line_edge_if.sv
// Carrier for a synchronised input line and its edge pulses.
`timescale 1ns/10ps
`default_nettype none
interface line_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : line_edge_if
`default_nettype wire

// file: design/line_edge_detect.sv
// Two-stage synchroniser and edge detector for one input line.
`timescale 1ns/10ps
`default_nettype none
module line_edge_detect (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  input  wire logic   line_i,
  line_edge_if.src    edge_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= line_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign edge_o.level = sync_reg;
  assign edge_o.rise  = sync_reg & ~last_reg;
  assign edge_o.fall  = ~sync_reg & last_reg;
endmodule : line_edge_detect
`default_nettype wire

// file: design/frame_start_trigger_control.sv
// Frame start trigger control with an AXI4-Lite register slave.
// Functional notes
// - Trigger logic acts only in standard mode; reset leaves legacy mode selected.
// - While waiting for frame start, each frame trigger starts one frame.
// - Frame triggers are ignored outside the waiting-for-frame-start status.
// - Waiting-for-frame needs valid mode, begin command, and acquisition trigger if enabled.
// - Frame trigger mode off means all frame triggers are made internally.
// - Internal triggering in single frame mode gives one trigger per begin command.
// - Internal triggering in continuous mode runs from begin until end command.
// - Rate limit disabled: internal triggers run at the maximum allowed rate.
// - Rate limit enabled and slower than maximum: triggers follow programmed rate.
// - Rate limit faster than maximum allowed: triggers clamp to maximum rate.
// - Frame trigger mode off: exposure length is the programmed exposure value.
// - Software source: each host software trigger command is one frame trigger; the code takes it as an acquisition trigger when CTRL_TRIG_KIND is set.
// - Line source: the external line signal is the frame start trigger.
// - Line source fires on rising or falling edge as polarity selects.
// - After reset the frame trigger source is input line one.
// - Software source: exposure length is the programmed exposure value.
// - Line source: exposure from programmed value or from trigger pulse width.
// - Exposure start leaves waiting status; return when a trigger can be taken.
// - Triggers arriving while not waiting for frame start are silently dropped.
// - With acquisition triggering, return to waiting-for-acquisition after programmed frame count.
`timescale 1ns/10ps
`default_nettype none
module frame_start_trigger_control
  import fst_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        frame_line_i,
  input  wire logic        acq_line_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             frame_start_o,
  output logic             exposure_active_o,
  output logic             wait_frame_o,
  output logic             wait_acq_o
);
  if (CNT_W < 8 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 8 and 32");
  end

  // ****************************************************************
  // Register write port
  // ****************************************************************
  logic [7:0]       aw_addr_reg;
  logic             aw_full_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             w_full_reg;
  logic             awready_reg;
  logic             wready_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic [CTRL_BITS-1:0] ctrl_reg;
  logic [31:0]      rate_period_reg;
  logic [31:0]      min_period_reg;
  logic [31:0]      exposure_reg;
  logic [31:0]      frames_reg;
  logic [31:0]      readout_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] addr);
    return addr[1:0] == 2'b00 && addr <= STATUS_OFS;
  endfunction : mapped

  wire aw_take   = s_axi_awvalid_i & awready_reg;
  wire w_take    = s_axi_wvalid_i & wready_reg;
  wire wr_do     = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire aw_next   = (aw_full_reg | aw_take) & ~wr_do;
  wire w_next    = (w_full_reg | w_take) & ~wr_do;
  wire wr_ok     = mapped(aw_addr_reg) && aw_addr_reg != STATUS_OFS;
  wire cmd_wr    = wr_do && aw_addr_reg == CMD_OFS && w_strb_reg[0];
  wire acq_begin_cmd = cmd_wr & w_data_reg[CMD_BEGIN];
  wire acq_end_cmd   = cmd_wr & w_data_reg[CMD_END];
  wire sw_trig_cmd   = cmd_wr & w_data_reg[CMD_SW_TRIG];
  wire [31:0] ctrl_merged = merge({{(32-CTRL_BITS){1'b0}}, ctrl_reg}, w_data_reg, w_strb_reg);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_addr_reg <= 8'h00;
      aw_full_reg <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_take) aw_addr_reg <= s_axi_awaddr_i;
      if (w_take) begin
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      aw_full_reg <= aw_next;
      w_full_reg  <= w_next;
      awready_reg <= ~aw_next;
      wready_reg  <= ~w_next;
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Reset selects legacy mode and the line source.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg        <= CTRL_RESET;
      rate_period_reg <= RATE_PERIOD_RESET;
      min_period_reg  <= MIN_PERIOD_RESET;
      exposure_reg    <= EXPOSURE_RESET;
      frames_reg      <= FRAMES_RESET;
      readout_reg     <= READOUT_RESET;
    end else if (wr_do) begin
      case (aw_addr_reg)
        CTRL_OFS:        ctrl_reg        <= ctrl_merged[CTRL_BITS-1:0];
        RATE_PERIOD_OFS: rate_period_reg <= merge(rate_period_reg, w_data_reg, w_strb_reg);
        MIN_PERIOD_OFS:  min_period_reg  <= merge(min_period_reg, w_data_reg, w_strb_reg);
        EXPOSURE_OFS:    exposure_reg    <= merge(exposure_reg, w_data_reg, w_strb_reg);
        FRAMES_OFS:      frames_reg      <= merge(frames_reg, w_data_reg, w_strb_reg);
        READOUT_OFS:     readout_reg     <= merge(readout_reg, w_data_reg, w_strb_reg);
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Input lines and trigger qualification
  // ****************************************************************
  line_edge_if frame_line ();
  line_edge_if acq_line ();

  line_edge_detect u_frame_line (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .line_i  (frame_line_i),
    .edge_o  (frame_line)
  );

  line_edge_detect u_acq_line (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .line_i  (acq_line_i),
    .edge_o  (acq_line)
  );

  acq_state_t       state_reg;
  acq_state_t       state_next;
  logic [CNT_W-1:0] pace_reg;
  logic [CNT_W-1:0] timer_reg;
  logic [31:0]      frame_cnt_reg;
  logic             single_pending_reg;
  logic             width_exp_reg;

  wire std_mode      = ctrl_reg[CTRL_STD_MODE];
  wire frame_trig_enable     = ctrl_reg[CTRL_FRAME_TRIG];
  wire frame_trig_source_sel = ctrl_reg[CTRL_FRAME_SRC];
  wire edge_polarity_sel     = ctrl_reg[CTRL_EDGE_POL];
  wire acq_mode_sel          = ctrl_reg[CTRL_ACQ_MODE];
  wire frame_rate_limit_en   = ctrl_reg[CTRL_RATE_LIMIT];
  wire acq_trig_en           = ctrl_reg[CTRL_ACQ_TRIG];
  wire acq_trig_sw_src       = ctrl_reg[CTRL_ACQ_SRC];
  wire trig_kind_sel         = ctrl_reg[CTRL_TRIG_KIND];
  wire exp_by_width          = ctrl_reg[CTRL_EXP_WIDTH];

  // Polarity picks the edge that counts and the level that means "held".
  wire line_edge   = edge_polarity_sel ? frame_line.fall : frame_line.rise;
  wire line_active = frame_line.level ^ edge_polarity_sel;
  wire acq_edge    = edge_polarity_sel ? acq_line.fall : acq_line.rise;
  wire sw_frame    = sw_trig_cmd & ~trig_kind_sel;
  wire sw_acq      = sw_trig_cmd & trig_kind_sel;
  wire ext_trig    = frame_trig_source_sel ? sw_frame : line_edge;
  // An internal trigger needs the pacing counter expired; single mode also a pending shot.
  wire int_trig    = pace_reg == '0 && (acq_mode_sel || single_pending_reg);
  wire frame_trig  = frame_trig_enable ? ext_trig : int_trig;
  // Triggers outside the waiting status fall through here unseen.
  wire frame_take  = state_reg == ST_WAIT_FRAME && frame_trig;
  wire acq_trig    = acq_trig_sw_src ? sw_acq : acq_edge;
  // Periods in cycles: a larger period is a slower rate, so the clamp takes the larger.
  wire [31:0] eff_period = (frame_rate_limit_en && rate_period_reg > min_period_reg)
                           ? rate_period_reg : min_period_reg;
  wire last_frame  = acq_trig_en && frame_cnt_reg + 32'h1 >= frames_reg;
  wire use_width   = frame_trig_enable && !frame_trig_source_sel && exp_by_width;
  wire timer_done  = timer_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
  wire expose_done = width_exp_reg ? !line_active : timer_done;
  wire readout_done = timer_done;

  // Acquisition triggering requires continuous mode, as single frame cannot be counted.
  wire mode_valid  = !acq_trig_en || acq_mode_sel;
  wire after_frame_idle = !acq_mode_sel && !single_pending_reg;

  // ****************************************************************
  // Acquisition state machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (std_mode && acq_begin_cmd && mode_valid) begin
          state_next = acq_trig_en ? ST_WAIT_ACQ : ST_WAIT_FRAME;
        end
      end
      ST_WAIT_ACQ: begin
        if (acq_trig) state_next = ST_WAIT_FRAME;
      end
      ST_WAIT_FRAME: begin
        if (frame_take) state_next = ST_EXPOSE;
      end
      ST_EXPOSE: begin
        if (expose_done) state_next = ST_READOUT;
      end
      ST_READOUT: begin
        if (readout_done) begin
          if (last_frame) state_next = ST_WAIT_ACQ;
          else if (after_frame_idle) state_next = ST_IDLE;
          else state_next = ST_WAIT_FRAME;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (acq_end_cmd || !std_mode) state_next = ST_IDLE;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg          <= ST_IDLE;
      single_pending_reg <= 1'b0;
      width_exp_reg      <= 1'b0;
      frame_cnt_reg      <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && state_next != ST_IDLE) begin
        single_pending_reg <= 1'b1;
        frame_cnt_reg      <= 32'h0000_0000;
      end else if (frame_take) begin
        single_pending_reg <= 1'b0;
        width_exp_reg      <= use_width;
      end
      if (state_reg == ST_READOUT && readout_done) begin
        frame_cnt_reg <= last_frame ? 32'h0000_0000 : frame_cnt_reg + 32'h1;
      end
    end
  end

  // Pacing runs from each frame start, so internal triggers never come closer than the period.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pace_reg  <= '0;
      timer_reg <= '0;
    end else begin
      if (frame_take) pace_reg <= eff_period[CNT_W-1:0] - 1'b1;
      else if (pace_reg != '0) pace_reg <= pace_reg - 1'b1;
      if (frame_take) timer_reg <= exposure_reg[CNT_W-1:0];
      else if (state_reg == ST_EXPOSE && expose_done) timer_reg <= readout_reg[CNT_W-1:0];
      else if (timer_reg != '0) timer_reg <= timer_reg - 1'b1;
    end
  end

  // ****************************************************************
  // Outputs and register read port
  // ****************************************************************
  logic        frame_start_reg;
  logic        exposure_reg_q;
  logic        wait_frame_reg;
  logic        wait_acq_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire [31:0] status_word = {frame_cnt_reg[15:0], 12'h000,
                             state_reg == ST_READOUT, state_reg == ST_EXPOSE,
                             state_reg == ST_WAIT_ACQ, state_reg == ST_WAIT_FRAME};
  wire [31:0] rd_word =
      (s_axi_araddr_i == CTRL_OFS)        ? {{(32-CTRL_BITS){1'b0}}, ctrl_reg} :
      (s_axi_araddr_i == RATE_PERIOD_OFS) ? rate_period_reg :
      (s_axi_araddr_i == MIN_PERIOD_OFS)  ? min_period_reg :
      (s_axi_araddr_i == EXPOSURE_OFS)    ? exposure_reg :
      (s_axi_araddr_i == FRAMES_OFS)      ? frames_reg :
      (s_axi_araddr_i == READOUT_OFS)     ? readout_reg :
      (s_axi_araddr_i == STATUS_OFS)      ? status_word : 32'h0000_0000;
  wire ar_take = s_axi_arvalid_i & arready_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      frame_start_reg <= 1'b0;
      exposure_reg_q  <= 1'b0;
      wait_frame_reg  <= 1'b0;
      wait_acq_reg    <= 1'b0;
      arready_reg     <= 1'b0;
      rvalid_reg      <= 1'b0;
      rdata_reg       <= 32'h0000_0000;
      rresp_reg       <= RESP_OKAY;
    end else begin
      frame_start_reg <= frame_take;
      exposure_reg_q  <= state_next == ST_EXPOSE;
      wait_frame_reg  <= state_next == ST_WAIT_FRAME;
      wait_acq_reg    <= state_next == ST_WAIT_ACQ;
      arready_reg     <= ~rvalid_reg & ~ar_take & ~(rvalid_reg & ~s_axi_rready_i);
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o   = awready_reg;
  assign s_axi_wready_o    = wready_reg;
  assign s_axi_bvalid_o    = bvalid_reg;
  assign s_axi_bresp_o     = bresp_reg;
  assign s_axi_arready_o   = arready_reg;
  assign s_axi_rvalid_o    = rvalid_reg;
  assign s_axi_rdata_o     = rdata_reg;
  assign s_axi_rresp_o     = rresp_reg;
  assign frame_start_o     = frame_start_reg;
  assign exposure_active_o = exposure_reg_q;
  assign wait_frame_o      = wait_frame_reg;
  assign wait_acq_o        = wait_acq_reg;
endmodule : frame_start_trigger_control
`default_nettype wire

// file: verification/frame_start_trigger_control_monitor.sv
// Port checker for the frame start trigger control block.
`timescale 1ns/10ps
`default_nettype none
module fst_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic frame_start_o,
  input wire logic exposure_active_o,
  input wire logic wait_frame_o,
  input wire logic wait_acq_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_pulse_single: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start pulse longer than one cycle");
  a_start_needs_wait: assert property ($rose(frame_start_o) |-> $past(wait_frame_o))
    else $error("frame start without waiting status");
  a_start_exposes: assert property (frame_start_o |-> exposure_active_o)
    else $error("frame start without exposure");
  a_start_leaves_wait: assert property (frame_start_o |-> !wait_frame_o)
    else $error("still waiting during exposure start");
  a_wait_exclusive: assert property (!(wait_frame_o && wait_acq_o))
    else $error("both waiting states at once");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write answer late");
  a_aw_refused: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("write address taken twice");
endmodule : fst_monitor
bind frame_start_trigger_control fst_monitor u_fst_monitor (.clk_i(clk_i), .reset_i(reset_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .frame_start_o(frame_start_o), .exposure_active_o(exposure_active_o),
  .wait_frame_o(wait_frame_o), .wait_acq_o(wait_acq_o));
`default_nettype wire

// file: verification/trig_line_model.sv
// External trigger source driving the frame and acquisition lines.
`timescale 1ns/10ps
`default_nettype none
module trig_line_model (
  input  wire logic clk_i,
  output logic      frame_line_o,
  output logic      acq_line_o
);
  // Lines rest low as if pulled down while the source is idle.
  initial begin
    frame_line_o = 1'b0;
    acq_line_o = 1'b0;
  end
  task automatic drive_frame(input logic v);
    @(posedge clk_i);
    frame_line_o <= v;
  endtask : drive_frame
  task automatic drive_acq(input logic v);
    @(posedge clk_i);
    acq_line_o <= v;
  endtask : drive_acq
endmodule : trig_line_model
`default_nettype wire

// file: verification/test_frame_start_trigger_control.sv
// Self-checking testbench for the frame start trigger control block.
`timescale 1ns/10ps
`default_nettype none
module test_frame_start_trigger_control;
  import fst_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, e;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fs, expo, wfr, wacq, fl, al;
  logic [1:0] bresp, rresp, bseen;
  int errors = 0, comparisons = 0, cyc = 0, seed = 10228, fs_cnt = 0, last = -1, elen = 0, base;
  logic [33:0] rd_q[$];
  int gap_q[$], exp_q[$];
  logic [7:0] ofs[6] = '{CTRL_OFS, RATE_PERIOD_OFS, MIN_PERIOD_OFS, EXPOSURE_OFS, FRAMES_OFS,
                         READOUT_OFS};
  logic [31:0] rv[6] = '{32'h0, RATE_PERIOD_RESET, MIN_PERIOD_RESET, EXPOSURE_RESET,
                         FRAMES_RESET, READOUT_RESET};
  logic [31:0] t_ctrl[3] = '{32'h11, 32'h31, 32'h31};
  logic [31:0] t_rate[3] = '{32'h3c, 32'h3c, 32'h14};
  logic [31:0] t_gap[3] = '{32'h28, 32'h3c, 32'h28};
  always #10 clk_i = ~clk_i;
  frame_start_trigger_control u_frame_start_trigger_control (.clk_i(clk_i), .reset_i(reset_i),
    .frame_line_i(fl), .acq_line_i(al), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .frame_start_o(fs), .exposure_active_o(expo), .wait_frame_o(wfr), .wait_acq_o(wacq));
  trig_line_model u_trig_line_model (.clk_i(clk_i), .frame_line_o(fl), .acq_line_o(al));
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
    comparisons++;
    if (g !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bseen = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rd_q.push_back({RESP_OKAY, x});
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle
  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) chk("read", rd_q.pop_front(), {rresp, rdata});
    if (fs === 1'b1) begin
      fs_cnt++;
      if (last >= 0 && gap_q.size() > 0) chk("frame gap", gap_q.pop_front(), cyc - last);
      last = cyc;
    end
    elen <= (expo === 1'b1) ? elen + 1 : 0;
    if (expo === 1'b0 && elen > 0 && exp_q.size() > 0) chk("exposure", exp_q.pop_front(), elen);
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ofs[i], rv[i]);
    wr(STATUS_OFS, 32'h0);
    chk("status write", RESP_SLVERR, bseen);
    wr(8'h20, 32'h0);
    chk("unmapped write", RESP_SLVERR, bseen);
    $display("test registers done");
    wr(MIN_PERIOD_OFS, 32'h28); wr(EXPOSURE_OFS, 32'h5); wr(READOUT_OFS, 32'h5);
    wr(CTRL_OFS, 32'h10); base = fs_cnt; wr(CMD_OFS, 32'h1); idle(200);
    chk("legacy frames", 0, fs_cnt - base);
    wr(CMD_OFS, 32'h2);
    $display("test legacy done");
    for (int i = 0; i < 3; i++) begin
      wr(CTRL_OFS, t_ctrl[i]); wr(RATE_PERIOD_OFS, t_rate[i]);
      last = -1; gap_q = '{t_gap[i], t_gap[i]}; exp_q = '{5};
      wr(CMD_OFS, 32'h1); idle(300); wr(CMD_OFS, 32'h2);
      chk("gaps seen", 0, gap_q.size());
      base = fs_cnt; idle(100);
      chk("after end", 0, fs_cnt - base);
    end
    $display("test internal rate done");
    wr(CTRL_OFS, 32'h01); base = fs_cnt; wr(CMD_OFS, 32'h1); idle(300);
    chk("single frame", 1, fs_cnt - base);
    $display("test single done");
    e = 32'h4 + ($random(seed) & 32'h7);
    wr(EXPOSURE_OFS, e); exp_q = '{e};
    wr(CTRL_OFS, 32'h17); wr(CMD_OFS, 32'h1); idle(5);
    chk("wait frame", 1'b1, wfr);
    base = fs_cnt; wr(CMD_OFS, 32'h4); wr(CMD_OFS, 32'h4); idle(50);
    chk("software frames", 1, fs_cnt - base);
    chk("exposure seen", 0, exp_q.size());
    wr(CMD_OFS, 32'h2); wr(EXPOSURE_OFS, 32'h5);
    $display("test software done");
    for (int p = 0; p < 3; p++) begin
      wr(CTRL_OFS, p == 2 ? 32'h213 : p ? 32'h1b : 32'h13); wr(CMD_OFS, 32'h1); idle(5);
      base = fs_cnt; exp_q = '{p == 2 ? 16 : 5};
      u_trig_line_model.drive_frame(1'b1); idle(15);
      chk("after rise", p == 1 ? 0 : 1, fs_cnt - base);
      u_trig_line_model.drive_frame(1'b0); idle(15);
      chk("after fall", 1, fs_cnt - base);
      chk("line exposure seen", 0, exp_q.size());
      wr(CMD_OFS, 32'h2);
    end
    $display("test line done");
    wr(FRAMES_OFS, 32'h2); wr(CTRL_OFS, 32'h57); wr(CMD_OFS, 32'h1); idle(5);
    chk("wait acq", 1'b1, wacq);
    u_trig_line_model.drive_acq(1'b1); idle(10);
    chk("acq taken", 1'b1, wfr);
    u_trig_line_model.drive_acq(1'b0);
    repeat (2) begin
      wr(CMD_OFS, 32'h4); idle(30);
    end
    chk("back to acq wait", 1'b1, wacq);
    wr(CTRL_OFS, 32'h1d7); wr(CMD_OFS, 32'h4); idle(3);
    chk("software acq trigger", 1'b1, wfr);
    $display("test acquisition trigger done");
    final_report();
  end
endmodule : test_frame_start_trigger_control
`default_nettype wire
